// ===== verilog/ccd_pkg.sv
// Constants and types shared by the clear/complement/decrement execute block
`default_nettype none
package ccd_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] INSTR_OFS     = 12'h000;
  localparam logic [11:0] WORK_OFS      = 12'h004;
  localparam logic [11:0] STATUS_OFS    = 12'h008;
  localparam logic [11:0] DOG_OFS       = 12'h00C;
  localparam logic [11:0] FILE_BASE_OFS = 12'h100;
  localparam logic [11:0] FILE_END_OFS  = 12'h300;

  // Status register field positions
  localparam int ZERO_BIT = 0;
  localparam int PD_BIT   = 1;
  localparam int TO_BIT   = 2;
  localparam int BAD_BIT  = 3;

  // Values after reset
  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic [7:0]  FILE_RST = 8'h00;
  localparam logic [7:0]  DOG_RST  = 8'h00;
  localparam logic        ZERO_RST = 1'b0;
  localparam logic        PD_RST   = 1'b1;
  localparam logic        TO_RST   = 1'b1;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  // Opcode patterns and masks
  localparam logic [13:0] CLR_FILE_MASK = 14'h3F80;
  localparam logic [13:0] CLR_FILE_VAL  = 14'h0080;
  localparam logic [13:0] CLR_WORK_VAL  = 14'h0140;
  localparam logic [13:0] CLR_DOG_VAL   = 14'h0004;
  localparam logic [13:0] FILE_OP_MASK  = 14'h3F00;
  localparam logic [13:0] INV_FILE_VAL  = 14'h0900;
  localparam logic [13:0] DEC_FILE_VAL  = 14'h0300;

  // Watchdog tick timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          DOG_TICK_NS   = 5000;
  localparam int          DOG_TICK_CYC  = DOG_TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  DOG_DIV_LAST  = 8'(DOG_TICK_CYC - 1);
  localparam logic [7:0]  DOG_WRAP      = 8'hFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE,
    CLEAR_FILE_OP,
    CLEAR_WORK_OP,
    CLEAR_DOG_TIMER_OP,
    INVERT_FILE_OP,
    DECREMENT_FILE_OP
  } ccd_op_t;

endpackage
`default_nettype wire

// ===== verilog/ccd_dec_if.sv
// Interface carrying an opcode to the decoder and its decoded fields back
`timescale 1ns/10ps
`default_nettype none
interface ccd_dec_if;
  import ccd_pkg::*;
  logic [13:0] opcode;
  ccd_op_t     op;
  logic [6:0]  faddr;
  logic        dest;

  modport decoder (input opcode, output op, output faddr, output dest);
  modport core    (output opcode, input op, input faddr, input dest);
endinterface
`default_nettype wire

// ===== verilog/ccd_decode.sv
// Opcode decoder for the five clear/complement/decrement instructions
`timescale 1ns/10ps
`default_nettype none
module ccd_decode
  import ccd_pkg::*;
(
  ccd_dec_if.decoder dec
);

  // Operand fields sit at fixed places in every file instruction
  assign dec.faddr = dec.opcode[6:0];
  assign dec.dest  = dec.opcode[7];

  // Exact matches first; masked matches cannot overlap them
  always_comb
  begin
    if (dec.opcode == CLR_WORK_VAL)
      dec.op = CLEAR_WORK_OP;
    else if (dec.opcode == CLR_DOG_VAL)
      dec.op = CLEAR_DOG_TIMER_OP;
    else if ((dec.opcode & CLR_FILE_MASK) == CLR_FILE_VAL)
      dec.op = CLEAR_FILE_OP;
    else if ((dec.opcode & FILE_OP_MASK) == INV_FILE_VAL)
      dec.op = INVERT_FILE_OP;
    else if ((dec.opcode & FILE_OP_MASK) == DEC_FILE_VAL)
      dec.op = DECREMENT_FILE_OP;
    else
      dec.op = OP_NONE;
  end

endmodule // ccd_decode
`default_nettype wire

// ===== verilog/ccd_exec.sv
// Execute core for clear/complement/decrement instructions with AXI4-Lite access
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ccd_exec
  import ccd_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic [11:0] AXI_AWADDR_I,
  input  wire logic        AXI_AWVALID_I,
  output logic             AXI_AWREADY_O,
  input  wire logic [31:0] AXI_WDATA_I,
  input  wire logic [3:0]  AXI_WSTRB_I,
  input  wire logic        AXI_WVALID_I,
  output logic             AXI_WREADY_O,
  output logic [1:0]       AXI_BRESP_O,
  output logic             AXI_BVALID_O,
  input  wire logic        AXI_BREADY_I,
  input  wire logic [11:0] AXI_ARADDR_I,
  input  wire logic        AXI_ARVALID_I,
  output logic             AXI_ARREADY_O,
  output logic [31:0]      AXI_RDATA_O,
  output logic [1:0]       AXI_RRESP_O,
  output logic             AXI_RVALID_O,
  input  wire logic        AXI_RREADY_I
);

  typedef struct packed {
    logic              aw_held;
    logic [11:0]       awaddr;
    logic              w_held;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [13:0]       last_op;
    logic [7:0]        work;
    logic              zero;
    logic              power_down_flag;
    logic              timeout_flag;
    logic              bad_op;
    logic [7:0]        watchdog_count;
    logic [7:0]        presc;
    logic [127:0][7:0] file;
  } ccd_state_t;

  ccd_state_t q;
  ccd_state_t d;
  ccd_dec_if  dec ();
  logic       commit;
  logic       exec;
  logic [7:0] src;
  logic [7:0] alu_res;
  logic       dog_clear;
  logic       dog_wrap;

  ccd_decode u_decode (
    .dec (dec)
  );

  // Address window of the file register array, used by read and write paths
  function automatic logic in_file(input logic [11:0] a);
    return (a >= FILE_BASE_OFS) && (a < FILE_END_OFS);
  endfunction

  function automatic logic [6:0] file_idx(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - FILE_BASE_OFS;
    return rel[8:2];
  endfunction

  // Handshake outputs are combinational; one write and one read in flight
  assign AXI_AWREADY_O = ~q.aw_held & ~q.bvalid;
  assign AXI_WREADY_O  = ~q.w_held & ~q.bvalid;
  assign AXI_ARREADY_O = ~q.rvalid;
  assign AXI_BVALID_O  = q.bvalid;
  assign AXI_BRESP_O   = q.bresp;
  assign AXI_RVALID_O  = q.rvalid;
  assign AXI_RDATA_O   = q.rdata;
  assign AXI_RRESP_O   = q.rresp;

  // Held write data is the opcode; both lanes must be strobed to execute
  assign dec.opcode = q.wdata[13:0];
  assign commit     = q.aw_held & q.w_held & ~q.bvalid;
  assign exec       = commit & ({q.awaddr[11:2], 2'b00} == INSTR_OFS) & (&q.wstrb[1:0]);
  assign src        = q.file[dec.faddr];
  assign alu_res    = (dec.op == INVERT_FILE_OP) ? ~src : src - 8'h01;
  assign dog_clear  = exec & (dec.op == CLEAR_DOG_TIMER_OP);

  // Count overflow this cycle; must beat a status write landing in the same cycle
  assign dog_wrap   = ~dog_clear & (q.presc == DOG_DIV_LAST) & (q.watchdog_count == DOG_WRAP);

  // Next-state logic: bus capture, register writes, execution, watchdog tick
  always_comb
  begin
    logic [11:0] wa;
    logic [11:0] ra;
    d  = q;
    wa = {q.awaddr[11:2], 2'b00};
    ra = {AXI_ARADDR_I[11:2], 2'b00};
    if (AXI_AWVALID_I && AXI_AWREADY_O)
    begin
      d.aw_held = 1'b1;
      d.awaddr  = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && AXI_WREADY_O)
    begin
      d.w_held = 1'b1;
      d.wdata  = AXI_WDATA_I;
      d.wstrb  = AXI_WSTRB_I;
    end
    if (q.bvalid && AXI_BREADY_I)
      d.bvalid = 1'b0;
    if (q.rvalid && AXI_RREADY_I)
      d.rvalid = 1'b0;
    // Watchdog prescaler; held off in a clear so the clear is not undone
    if (!dog_clear)
    begin
      d.presc = (q.presc == DOG_DIV_LAST) ? 8'h00 : q.presc + 8'h01;
      if (q.presc == DOG_DIV_LAST)
      begin
        d.watchdog_count = q.watchdog_count + 8'h01;
        if (q.watchdog_count == DOG_WRAP)
          d.timeout_flag = 1'b0;       // Overflow marks a timeout
      end
    end
    // Write commit: one cycle after both address and data are held
    if (commit)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (in_file(wa))
      begin
        if (q.wstrb[0])
          d.file[file_idx(wa)] = q.wdata[7:0];
      end
      else if (wa == INSTR_OFS)
      begin
        if (exec)
        begin
          d.last_op = q.wdata[13:0];
          case (dec.op)
            CLEAR_FILE_OP:
            begin
              d.file[dec.faddr] = FILE_RST;
              d.zero            = 1'b1;
            end
            CLEAR_WORK_OP:
            begin
              d.work = 8'h00;
              d.zero = 1'b1;
            end
            CLEAR_DOG_TIMER_OP:
            begin
              d.watchdog_count  = DOG_RST;
              d.presc           = 8'h00;
              d.timeout_flag    = 1'b1;
              d.power_down_flag = 1'b1;
            end
            INVERT_FILE_OP, DECREMENT_FILE_OP:
            begin
              if (dec.dest)
                d.file[dec.faddr] = alu_res;
              else
                d.work = alu_res;
              d.zero = (alu_res == 8'h00);
            end
            default:
              d.bad_op = 1'b1;                // Unknown opcodes only flag
          endcase
        end
      end
      else if (wa == WORK_OFS)
      begin
        if (q.wstrb[0])
          d.work = q.wdata[7:0];
      end
      else if (wa == STATUS_OFS)
      begin
        if (q.wstrb[0])
        begin
          d.zero            = q.wdata[ZERO_BIT];
          d.power_down_flag = q.wdata[PD_BIT];
          d.timeout_flag    = q.wdata[TO_BIT] & ~dog_wrap;  // Timeout event wins
          d.bad_op          = q.wdata[BAD_BIT];
        end
      end
      else if (wa != DOG_OFS)
        d.bresp = RESP_SLVERR;         // Count is read only; writes ignored
    end
    // Read capture: data sampled from current state
    if (AXI_ARVALID_I && AXI_ARREADY_O)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (in_file(ra))
        d.rdata[7:0] = q.file[file_idx(ra)];
      else if (ra == INSTR_OFS)
        d.rdata[13:0] = q.last_op;
      else if (ra == WORK_OFS)
        d.rdata[7:0] = q.work;
      else if (ra == STATUS_OFS)
        d.rdata[3:0] = {q.bad_op, q.timeout_flag, q.power_down_flag, q.zero};
      else if (ra == DOG_OFS)
        d.rdata[7:0] = q.watchdog_count;
      else
        d.rresp = RESP_SLVERR;
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      q                 <= '0;
      q.last_op         <= INSTR_RST;
      q.work            <= WORK_RST;
      q.zero            <= ZERO_RST;
      q.power_down_flag <= PD_RST;
      q.timeout_flag    <= TO_RST;
      q.watchdog_count  <= DOG_RST;
    end
    else
      q <= d;
  end

  // Checks on execution and bus behaviour
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence rd_taken;
    AXI_ARVALID_I && AXI_ARREADY_O;
  endsequence

  sequence rd_answer;
    AXI_RVALID_O && !AXI_ARREADY_O;
  endsequence

  clear_file_a: assert property (exec && dec.op == CLEAR_FILE_OP |=>
      q.file[$past(dec.faddr)] == 8'h00 && q.zero)
    else $error("clear file did not zero register and set zero");
  operand_field_a: assert property (dec.faddr == q.wdata[6:0] && dec.dest == q.wdata[7])
    else $error("file operand fields misplaced");
  clear_work_a: assert property (exec && dec.op == CLEAR_WORK_OP |=>
      q.work == 8'h00 && q.zero)
    else $error("clear work did not zero working register");
  dog_clear_a: assert property (dog_clear |=>
      q.watchdog_count == 8'h00 && q.timeout_flag && q.power_down_flag)
    else $error("dog clear did not reset count and flags");
  invert_work_a: assert property (exec && dec.op == INVERT_FILE_OP && !dec.dest |=>
      q.work == ~$past(src) && q.file == $past(q.file))
    else $error("invert to work wrong");
  decr_file_a: assert property (exec && dec.op == DECREMENT_FILE_OP && dec.dest |=>
      q.file[$past(dec.faddr)] == $past(src) - 8'h01 && q.work == $past(q.work))
    else $error("decrement to file wrong");
  dest_select_a: assert property (exec && dec.op == DECREMENT_FILE_OP && !dec.dest |=>
      q.work == $past(src) - 8'h01 && q.file == $past(q.file))
    else $error("decrement to work touched file array");
  zero_only_a: assert property (exec && (dec.op == INVERT_FILE_OP ||
      dec.op == DECREMENT_FILE_OP) |=> q.zero == ($past(alu_res) == 8'h00)
      && $stable(q.power_down_flag) && $stable(q.bad_op))
    else $error("zero flag or other flags wrong after file op");
  read_answer_a: assert property (rd_taken |=> rd_answer)
    else $error("read not answered one cycle after address");
  write_hold_a: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O)
    else $error("write response dropped before ready");

endmodule // ccd_exec
`default_nettype wire

// ===== verif/ccd_exec_tb.sv
// Self-checking bench for the clear/complement/decrement execute block
`timescale 1ns/10ps
`default_nettype none
module ccd_exec_tb;
  import ccd_pkg::*;
  localparam int CEIL = 20000;
  logic        clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_mismatch, check_count, cyc;

  ccd_exec uut (.CLK_SYS_I(clk_sys), .RST_I(rst), .AXI_AWADDR_I(awaddr),
    .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
    .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready));

  // Free-running 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the negedge, where it has settled for the coming edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, ta, tw, tb;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk_sys);
      if (ta)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do
    begin
      @(negedge clk_sys);
      tb = bvalid;
      r = bresp;
      @(posedge clk_sys);
    end while (!tb);
    bready <= 1'b0;
    @(posedge clk_sys);  // Idle edge so the next call never re-drives in this step
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = arready;
      @(posedge clk_sys);
    end while (!ta);
    arvalid <= 1'b0;
    do
    begin
      @(negedge clk_sys);
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
    end while (!tr);
    rready <= 1'b0;
    @(posedge clk_sys);  // Idle edge so the next call never re-drives in this step
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    chk(d, exp);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] f);
    return FILE_BASE_OFS + {3'h0, f, 2'h0};
  endfunction

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == CEIL)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // Invert/decrement table: base opcode, file value, destination
  localparam logic [13:0] T_OP [5] = '{INV_FILE_VAL, INV_FILE_VAL, DEC_FILE_VAL,
                                       DEC_FILE_VAL, INV_FILE_VAL};
  localparam logic [7:0]  T_IN [5] = '{8'h13, 8'hFF, 8'h01, 8'h00, 8'hFF};
  localparam logic        T_D  [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  res;
    logic [6:0]  f;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    {n_mismatch, check_count} = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset state
    rd_chk(STATUS_OFS, 32'h6);
    rd_chk(WORK_OFS, 32'h0);
    // Unmapped place refused both ways
    axi_rd(12'h010, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(12'h010, 32'h5A, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // Clear file at both ends of the address range
    foreach (T_IN[i])
    begin
      f = (i % 2) ? 7'h7F : 7'h00;
      wr(fa(f), 32'h5A);
      wr(STATUS_OFS, 32'h6);
      wr(INSTR_OFS, {18'h0, CLR_FILE_VAL | {7'h0, f}});
      rd_chk(fa(f), 32'h0);
      rd_chk(STATUS_OFS, 32'h7);
    end
    // Clear work
    wr(WORK_OFS, 32'h5A);
    wr(STATUS_OFS, 32'h6);
    wr(INSTR_OFS, {18'h0, CLR_WORK_VAL});
    rd_chk(WORK_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h7);
    // Drop all flags, let the timer run, then clear the timer
    wr(STATUS_OFS, 32'h0);
    repeat (600) @(posedge clk_sys);
    axi_rd(DOG_OFS, d, r);
    chk({31'h0, d[7:0] != 8'h00}, 32'h1);
    wr(INSTR_OFS, {18'h0, CLR_DOG_VAL});
    rd_chk(DOG_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h6);
    // Invert and decrement, both destinations, zero and non-zero results
    foreach (T_IN[i])
    begin
      f = 7'h40 + 7'(i);
      res = (T_OP[i] == INV_FILE_VAL) ? ~T_IN[i] : T_IN[i] - 8'h01;
      wr(fa(f), {24'h0, T_IN[i]});
      wr(WORK_OFS, 32'h11);
      wr(STATUS_OFS, {29'h0, 2'h3, res != 8'h00});
      wr(INSTR_OFS, {18'h0, T_OP[i] | {6'h0, T_D[i], f}});
      rd_chk(fa(f), {24'h0, T_D[i] ? res : T_IN[i]});
      rd_chk(WORK_OFS, {24'h0, T_D[i] ? 8'h11 : res});
      rd_chk(STATUS_OFS, {29'h0, 2'h3, res == 8'h00});
    end
    rd_chk(INSTR_OFS, {18'h0, INV_FILE_VAL | 14'h0044});
    // Unknown opcode only raises the bad-opcode flag; count writes are ignored
    wr(INSTR_OFS, 32'h3FFF);
    rd_chk(STATUS_OFS, 32'hF);
    wr(DOG_OFS, 32'h55);
    final_report();
  end
endmodule // ccd_exec_tb
`default_nettype wire
